// ===== rtl/spicfg_pkg.sv
// Register map, field layout and state encoding for the serial peripheral controller
package spicfg_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_MODE      = 8'h04;
	localparam logic [7:0] OFS_RDATA     = 8'h08;
	localparam logic [7:0] OFS_TDATA     = 8'h0C;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] OFS_IEN_SET   = 8'h14;
	localparam logic [7:0] OFS_IEN_CLR   = 8'h18;
	localparam logic [7:0] OFS_IEN_STATE = 8'h1C;
	localparam logic [7:0] OFS_CS0       = 8'h30;

	// Shared interrupt / status bit map
	localparam int IRQ_RX_FULL      = 0;
	localparam int IRQ_TX_HOLD_MT   = 1;
	localparam int IRQ_MODE_FAULT   = 2;
	localparam int IRQ_OVERRUN      = 3;
	localparam int IRQ_RX_END       = 4;
	localparam int IRQ_TX_END       = 5;
	localparam int IRQ_RX_BUF_FULL  = 6;
	localparam int IRQ_TX_BUF_MT    = 7;
	localparam int IRQ_SS_RISE      = 8;
	localparam int IRQ_TX_FULLY_MT  = 9;
	localparam int IRQ_W            = 10;
	localparam int STATUS_ENABLED   = 16;

	// Mode register fields
	localparam int MODE_ENABLE  = 0;
	localparam int MODE_VARSEL  = 1;
	localparam int MODE_DECODE  = 2;
	localparam int MODE_PCS_LSB = 16;
	localparam logic [31:0] MODE_MASK = 32'h000F_0007;

	// Transmit data register fields
	localparam int TD_PCS_LSB = 16;
	localparam int TD_LAST    = 24;

	// Per-select timing register fields
	localparam int CS_POL      = 0;
	localparam int CS_PHA      = 1;
	localparam int CS_HOLD     = 3;
	localparam int CS_BITS_LSB = 4;
	localparam int CS_DIV_LSB  = 8;
	localparam int CS_PRE_LSB  = 16;
	localparam int CS_ITD_LSB  = 24;
	localparam logic [31:0] CS_MASK  = 32'hFFFF_FFFB;
	localparam logic [31:0] CS_RESET = 32'h0000_0000;
	localparam int CS_COUNT = 4;

	// Character and timing constants
	localparam logic [4:0]  BITS_BASE     = 5'h08;
	localparam logic [3:0]  BITS_MAX_CODE = 4'h8;
	localparam logic [4:0]  DATA_BITS     = 5'h10;
	localparam logic [12:0] ITD_SCALE     = 13'h0020;
	localparam logic [12:0] CS_GAP_CYCLES = 13'h0006;
	localparam logic [3:0]  SEL_IDLE      = 4'hF;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		st_idle,
		st_pre,
		st_shift,
		st_itd,
		st_next,
		st_held,
		st_gap
	} spicfg_state_t;

endpackage : spicfg_pkg

// ===== rtl/spicfg_top.sv
// Serial peripheral controller: interrupt masks, per-select timing and serial engine
`timescale 1ns/100ps
module spicfg_top #(
	parameter int NUM_CS = 4
) (
	// Clock and reset
	input  logic        aclk,
	input  logic        aresetn,
	// Register bus, write side
	input  logic [7:0]  awaddr,
	input  logic        awvalid,
	output logic        awready,
	input  logic [31:0] wdata,
	input  logic [3:0]  wstrb,
	input  logic        wvalid,
	output logic        wready,
	output logic [1:0]  bresp,
	output logic        bvalid,
	input  logic        bready,
	// Register bus, read side
	input  logic [7:0]  araddr,
	input  logic        arvalid,
	output logic        arready,
	output logic [31:0] rdata,
	output logic [1:0]  rresp,
	output logic        rvalid,
	input  logic        rready,
	// Serial link
	output logic        serial_clock,
	output logic        mosi_out,
	input  logic        miso_in,
	output logic [3:0]  peripheral_select_out,
	input  logic        slave_select_in,
	// Buffer-controller status levels
	input  logic        rx_end_in,
	input  logic        tx_end_in,
	input  logic        rx_buffer_full_in,
	input  logic        tx_buffer_empty_in,
	// Interrupt
	output logic        irq
);

	if (NUM_CS != spicfg_pkg::CS_COUNT) begin : g_bad_cs
		$error("spicfg_top supports exactly four chip-select timing registers");
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (data & m);
	endfunction : merge

	function automatic logic [4:0] bits_of(input logic [31:0] c);
		logic [3:0] code;
		code = c[spicfg_pkg::CS_BITS_LSB +: 4];
		// Reserved codes clamp to the longest character rather than overrun the shifter
		if (code > spicfg_pkg::BITS_MAX_CODE)
			code = spicfg_pkg::BITS_MAX_CODE;
		return spicfg_pkg::BITS_BASE + {1'b0, code};
	endfunction : bits_of

	function automatic logic [7:0] half_len(input logic [7:0] div, input logic second);
		logic [7:0] h;
		h = second ? (div >> 1) : 8'((9'(div) + 9'h001) >> 1);
		// Divider 0 or 1 cannot be met with a registered clock; treated as the fastest rate
		return (h == 8'h00) ? 8'h01 : h;
	endfunction : half_len

	function automatic logic [12:0] pre_cycles(input logic [31:0] c);
		logic [7:0] pre;
		pre = c[spicfg_pkg::CS_PRE_LSB +: 8];
		return (pre == 8'h00) ? {5'h00, half_len(c[spicfg_pkg::CS_DIV_LSB +: 8], 1'b1)}
			: {5'h00, pre};
	endfunction : pre_cycles

	function automatic logic [1:0] csr_index(input logic [3:0] pcs, input logic dec);
		if (dec)
			return pcs[3:2];
		else if (!pcs[0])
			return 2'h0;
		else if (!pcs[1])
			return 2'h1;
		else if (!pcs[2])
			return 2'h2;
		else
			return 2'h3;
	endfunction : csr_index

	function automatic logic [3:0] sel_lines(input logic [3:0] pcs, input logic dec);
		return dec ? pcs : ~(4'h1 << csr_index(pcs, 1'b0));
	endfunction : sel_lines

	function automatic logic is_mapped(input logic [7:0] a);
		return a == spicfg_pkg::OFS_MODE || a == spicfg_pkg::OFS_RDATA
			|| a == spicfg_pkg::OFS_TDATA || a == spicfg_pkg::OFS_STATUS
			|| a == spicfg_pkg::OFS_IEN_SET || a == spicfg_pkg::OFS_IEN_CLR
			|| a == spicfg_pkg::OFS_IEN_STATE
			|| (a[7:4] == spicfg_pkg::OFS_CS0[7:4] && a[1:0] == 2'h0);
	endfunction : is_mapped

	spicfg_pkg::spicfg_state_t state;
	logic [31:0]               mode_reg;
	logic [31:0]               csr [NUM_CS];
	logic [spicfg_pkg::IRQ_W-1:0] ien;
	logic                      aw_held;
	logic                      w_held;
	logic [7:0]                aw_addr_q;
	logic [31:0]               w_data_q;
	logic [3:0]                w_strb_q;
	logic                      hold_valid;
	logic                      hold_last;
	logic [15:0]               hold_data;
	logic [3:0]                hold_pcs;
	logic                      rx_full;
	logic                      mode_fault;
	logic                      overrun;
	logic                      ss_rise;
	logic                      tx_fully_empty;
	logic [15:0]               rdata_q;
	logic [2:0]                ss_sync;
	logic [2:0]                miso_sync;
	logic                      ss_stable;
	logic                      miso_s;
	logic [1:0]                cur_idx;
	logic [3:0]                cur_sel;
	logic [15:0]               sh;
	logic [15:0]               rx_sh;
	logic                      mosi_q;
	logic                      sclk_q;
	logic                      last_q;
	logic [7:0]                hcnt;
	logic [5:0]                eidx;
	logic [12:0]               cnt;
	logic [31:0]               status;

	// Bus decode
	wire        wr_fire   = aw_held && w_held && !bvalid;
	wire        rd_fire   = arvalid && arready;
	wire [31:0] wbits     = merge(32'h0000_0000, w_data_q, w_strb_q);
	wire        wr_mode   = wr_fire && aw_addr_q == spicfg_pkg::OFS_MODE;
	wire        wr_tdata  = wr_fire && aw_addr_q == spicfg_pkg::OFS_TDATA;
	wire        wr_ien_st = wr_fire && aw_addr_q == spicfg_pkg::OFS_IEN_SET;
	wire        wr_ien_cl = wr_fire && aw_addr_q == spicfg_pkg::OFS_IEN_CLR;
	wire        wr_cs     = wr_fire && aw_addr_q[7:4] == spicfg_pkg::OFS_CS0[7:4]
		&& aw_addr_q[1:0] == 2'h0;
	wire        rd_status = rd_fire && araddr == spicfg_pkg::OFS_STATUS;
	wire        rd_rdata  = rd_fire && araddr == spicfg_pkg::OFS_RDATA;

	// Character selection and current configuration
	wire        enabled  = mode_reg[spicfg_pkg::MODE_ENABLE];
	wire        decode   = mode_reg[spicfg_pkg::MODE_DECODE];
	wire [3:0]  sel_pcs  = mode_reg[spicfg_pkg::MODE_VARSEL] ? hold_pcs
		: mode_reg[spicfg_pkg::MODE_PCS_LSB +: 4];
	wire [1:0]  next_idx = csr_index(sel_pcs, decode);
	wire [3:0]  next_sel = sel_lines(sel_pcs, decode);
	wire [31:0] cfg      = csr[cur_idx];
	wire [31:0] ld_cfg   = csr[next_idx];
	wire        cur_pol  = cfg[spicfg_pkg::CS_POL];
	wire        cur_pha  = cfg[spicfg_pkg::CS_PHA];
	wire        cur_hold = cfg[spicfg_pkg::CS_HOLD];
	wire [7:0]  cur_div  = cfg[spicfg_pkg::CS_DIV_LSB +: 8];
	wire [7:0]  cur_itd  = cfg[spicfg_pkg::CS_ITD_LSB +: 8];
	wire [4:0]  cur_bits = bits_of(cfg);
	wire [15:0] ld_word  = hold_data << (spicfg_pkg::DATA_BITS - bits_of(ld_cfg));

	// Serial edge timing
	wire        edge_now    = state == spicfg_pkg::st_shift && hcnt == 8'h01;
	wire        lead        = ~eidx[0];
	wire        last_edge   = eidx == ({cur_bits, 1'b0} - 6'h01);
	wire        capture_now = edge_now && (lead == cur_pha);
	wire        change_now  = edge_now && (cur_pha ? (!lead && !last_edge) : lead);
	wire        char_done   = edge_now && last_edge;
	wire [15:0] rx_next     = {rx_sh[14:0], miso_s};
	wire        same_sel    = hold_valid && next_sel == cur_sel && !last_q;
	wire        cont_now    = char_done && cur_itd == 8'h00 && same_sel;
	wire        take        = (state == spicfg_pkg::st_idle && enabled && hold_valid)
		|| (state == spicfg_pkg::st_held && enabled && same_sel)
		|| (state == spicfg_pkg::st_next && same_sel) || cont_now;
	wire        ss_settled  = ss_sync[1] == ss_sync[2];
	wire        ss_evt_rise = ss_settled && ss_sync[2] && !ss_stable;
	wire        ss_evt_fall = ss_settled && !ss_sync[2] && ss_stable;
	wire        tx_hold_mt  = enabled && !hold_valid;
	wire        link_idle   = state == spicfg_pkg::st_idle || state == spicfg_pkg::st_held;

	always_comb begin
		status = 32'h0000_0000;
		status[spicfg_pkg::IRQ_RX_FULL]     = rx_full;
		status[spicfg_pkg::IRQ_TX_HOLD_MT]  = tx_hold_mt;
		status[spicfg_pkg::IRQ_MODE_FAULT]  = mode_fault;
		status[spicfg_pkg::IRQ_OVERRUN]     = overrun;
		status[spicfg_pkg::IRQ_RX_END]      = rx_end_in;
		status[spicfg_pkg::IRQ_TX_END]      = tx_end_in;
		status[spicfg_pkg::IRQ_RX_BUF_FULL] = rx_buffer_full_in;
		status[spicfg_pkg::IRQ_TX_BUF_MT]   = tx_buffer_empty_in;
		status[spicfg_pkg::IRQ_SS_RISE]     = ss_rise;
		status[spicfg_pkg::IRQ_TX_FULLY_MT] = tx_fully_empty;
		status[spicfg_pkg::STATUS_ENABLED]  = enabled;
	end

	wire [31:0] rd_mux =
		(araddr == spicfg_pkg::OFS_MODE)      ? mode_reg :
		(araddr == spicfg_pkg::OFS_RDATA)     ? {16'h0000, rdata_q} :
		(araddr == spicfg_pkg::OFS_STATUS)    ? status :
		(araddr == spicfg_pkg::OFS_IEN_STATE) ? {{(32 - spicfg_pkg::IRQ_W){1'b0}}, ien} :
		(araddr[7:4] == spicfg_pkg::OFS_CS0[7:4] && araddr[1:0] == 2'h0) ? csr[araddr[3:2]] :
		32'h0000_0000;

	assign awready               = !aw_held && !bvalid;
	assign wready                = !w_held && !bvalid;
	assign arready               = !rvalid;
	assign serial_clock          = sclk_q;
	assign mosi_out              = mosi_q;
	assign peripheral_select_out = cur_sel;

	// Write channel: address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= spicfg_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_held   <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= is_mapped(aw_addr_q) ? spicfg_pkg::RESP_OKAY : spicfg_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= spicfg_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid <= 1'b1;
			rdata  <= rd_mux;
			rresp  <= is_mapped(araddr) ? spicfg_pkg::RESP_OKAY : spicfg_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// Software-written configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= 32'h0000_0000;
			ien      <= '0;
			for (int i = 0; i < NUM_CS; i++)
				csr[i] <= spicfg_pkg::CS_RESET;
		end else begin
			if (wr_mode)
				mode_reg <= merge(mode_reg, w_data_q, w_strb_q) & spicfg_pkg::MODE_MASK;
			if (wr_ien_st)
				ien <= ien | wbits[spicfg_pkg::IRQ_W-1:0];
			if (wr_ien_cl)
				ien <= ien & ~wbits[spicfg_pkg::IRQ_W-1:0];
			if (wr_cs)
				csr[aw_addr_q[3:2]] <= merge(csr[aw_addr_q[3:2]], w_data_q, w_strb_q)
					& spicfg_pkg::CS_MASK;
		end
	end

	// Transmit holding word; a new write wins over the engine taking the old one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_valid <= 1'b0;
			hold_data  <= 16'h0000;
			hold_pcs   <= 4'h0;
			hold_last  <= 1'b0;
		end else if (wr_tdata) begin
			hold_valid <= 1'b1;
			hold_data  <= wbits[15:0];
			hold_pcs   <= wbits[spicfg_pkg::TD_PCS_LSB +: 4];
			hold_last  <= wbits[spicfg_pkg::TD_LAST];
		end else if (take) begin
			hold_valid <= 1'b0;
		end
	end

	// Status flags: a setting event wins over a clearing read in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_full        <= 1'b0;
			overrun        <= 1'b0;
			mode_fault     <= 1'b0;
			ss_rise        <= 1'b0;
			tx_fully_empty <= 1'b0;
			rdata_q        <= 16'h0000;
			irq            <= 1'b0;
		end else begin
			rx_full    <= char_done || (rx_full && !rd_rdata);
			overrun    <= (char_done && rx_full && !rd_rdata) || (overrun && !rd_status);
			mode_fault <= (ss_evt_fall && enabled) || (mode_fault && !rd_status);
			ss_rise    <= ss_evt_rise || (ss_rise && !rd_status);
			tx_fully_empty <= !wr_tdata && !hold_valid && !take && link_idle;
			if (char_done)
				rdata_q <= capture_now ? rx_next : rx_sh;
			irq <= |(status[spicfg_pkg::IRQ_W-1:0] & ien);
		end
	end

	// Pin inputs: three stages, a change counts once stages two and three agree
	// Received bits come through this delay, so dividers below ten (below nine with the phase bit set) capture stale data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ss_sync   <= 3'h7;
			miso_sync <= 3'h0;
			ss_stable <= 1'b1;
			miso_s    <= 1'b0;
		end else begin
			ss_sync   <= {ss_sync[1:0], slave_select_in};
			miso_sync <= {miso_sync[1:0], miso_in};
			if (ss_settled)
				ss_stable <= ss_sync[2];
			if (miso_sync[1] == miso_sync[2])
				miso_s <= miso_sync[2];
		end
	end

	// Serial engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state   <= spicfg_pkg::st_idle;
			cur_idx <= 2'h0;
			cur_sel <= spicfg_pkg::SEL_IDLE;
			sh      <= 16'h0000;
			rx_sh   <= 16'h0000;
			mosi_q  <= 1'b0;
			sclk_q  <= 1'b0;
			last_q  <= 1'b0;
			hcnt    <= 8'h01;
			eidx    <= 6'h00;
			cnt     <= 13'h0000;
		end else begin
			case (state)
				spicfg_pkg::st_idle: begin
					sclk_q <= cur_pol;
				end
				spicfg_pkg::st_pre: begin
					cnt <= cnt - 13'h0001;
					if (cnt <= 13'h0002) begin
						state <= spicfg_pkg::st_shift;
						hcnt  <= 8'h01;
					end
				end
				spicfg_pkg::st_shift: begin
					if (edge_now) begin
						sclk_q <= ~sclk_q;
						if (capture_now)
							rx_sh <= rx_next;
						if (change_now) begin
							mosi_q <= sh[15];
							sh     <= {sh[14:0], 1'b0};
						end
						if (last_edge) begin
							state <= (cur_itd != 8'h00) ? spicfg_pkg::st_itd : spicfg_pkg::st_next;
							cnt   <= spicfg_pkg::ITD_SCALE * {5'h00, cur_itd};
						end else begin
							eidx <= eidx + 6'h01;
							hcnt <= half_len(cur_div, lead);
						end
					end else begin
						hcnt <= hcnt - 8'h01;
					end
				end
				spicfg_pkg::st_itd: begin
					cnt <= cnt - 13'h0001;
					if (cnt <= 13'h0001)
						state <= spicfg_pkg::st_next;
				end
				spicfg_pkg::st_next: begin
					if (!same_sel) begin
						if (!hold_valid && cur_hold && !last_q) begin
							state <= spicfg_pkg::st_held;
						end else begin
							state   <= spicfg_pkg::st_gap;
							cnt     <= spicfg_pkg::CS_GAP_CYCLES;
							cur_sel <= spicfg_pkg::SEL_IDLE;
						end
					end
				end
				spicfg_pkg::st_held: begin
					if ((hold_valid && next_sel != cur_sel) || !enabled) begin
						state   <= spicfg_pkg::st_gap;
						cnt     <= spicfg_pkg::CS_GAP_CYCLES;
						cur_sel <= spicfg_pkg::SEL_IDLE;
					end
				end
				spicfg_pkg::st_gap: begin
					cnt <= cnt - 13'h0001;
					if (cnt <= 13'h0001)
						state <= spicfg_pkg::st_idle;
				end
				default: begin
					state <= spicfg_pkg::st_idle;
				end
			endcase
			// Loading a character overrides whatever the state step chose
			if (take) begin
				cur_idx <= next_idx;
				cur_sel <= next_sel;
				last_q  <= hold_last;
				rx_sh   <= 16'h0000;
				eidx    <= 6'h00;
				if (ld_cfg[spicfg_pkg::CS_PHA]) begin
					mosi_q <= ld_word[15];
					sh     <= {ld_word[14:0], 1'b0};
				end else begin
					sh <= ld_word;
				end
				if (state == spicfg_pkg::st_idle) begin
					state  <= spicfg_pkg::st_pre;
					cnt    <= pre_cycles(ld_cfg);
					sclk_q <= ld_cfg[spicfg_pkg::CS_POL];
				end else begin
					state <= spicfg_pkg::st_shift;
					hcnt  <= half_len(ld_cfg[spicfg_pkg::CS_DIV_LSB +: 8], 1'b0);
				end
			end
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_ien_set_bits: assert property (wr_ien_st |=>
		(ien & $past(wbits[spicfg_pkg::IRQ_W-1:0])) == $past(wbits[spicfg_pkg::IRQ_W-1:0]))
		else $error("enable-set write did not enable its sources");
	a_ien_clr_bits: assert property (wr_ien_cl |=>
		(ien & $past(wbits[spicfg_pkg::IRQ_W-1:0])) == '0
		&& (ien | $past(wbits[spicfg_pkg::IRQ_W-1:0]))
			== ($past(ien) | $past(wbits[spicfg_pkg::IRQ_W-1:0])))
		else $error("enable-clear write changed the wrong sources");
	a_mask_readback: assert property ((rd_fire && araddr == spicfg_pkg::OFS_IEN_STATE) |=>
		rvalid && rdata == {{(32 - spicfg_pkg::IRQ_W){1'b0}}, $past(ien)})
		else $error("mask readback differs from enabled sources");
	a_ss_rise_flag: assert property (ss_evt_rise |=>
		ss_rise && status[spicfg_pkg::IRQ_SS_RISE])
		else $error("slave-select rise not flagged");
	a_tdr_clears_empty: assert property (wr_tdata |=> !tx_fully_empty ##1 !tx_fully_empty)
		else $error("fully-empty flag not cleared by transmit write");
	a_idle_clock_level: assert property ((state == spicfg_pkg::st_idle) ##1
		(state == spicfg_pkg::st_idle && $stable(cur_pol)) |-> serial_clock == cur_pol)
		else $error("serial clock idles at wrong level");
	a_phase_hold_data: assert property ((edge_now && lead && cur_pha && !take) |=>
		$stable(mosi_out))
		else $error("data changed on sampling edge");
	a_last_deselect: assert property ((char_done && last_q && cur_itd == 8'h00) |->
		##2 peripheral_select_out == spicfg_pkg::SEL_IDLE)
		else $error("last-transfer flag did not deselect");
	a_itd_load: assert property ($rose(state == spicfg_pkg::st_itd) |->
		cnt == spicfg_pkg::ITD_SCALE * {5'h00, cur_itd})
		else $error("inter-transfer delay length wrong");
	a_pre_load: assert property ($rose(state == spicfg_pkg::st_pre) |->
		cnt == pre_cycles(cfg))
		else $error("pre-clock delay length wrong");
	a_irq_output: assert property ((|(status[spicfg_pkg::IRQ_W-1:0] & ien)) |=> irq)
		else $error("interrupt missing for unmasked flag");
	a_decode_group: assert property ((state == spicfg_pkg::st_pre && decode) |->
		cur_idx == cur_sel[3:2])
		else $error("decoded select used wrong timing register");

	c_char_done: cover property (char_done);
	c_seamless: cover property (cont_now);
	c_held_select: cover property (state == spicfg_pkg::st_held);
	c_overrun: cover property (overrun);

endmodule : spicfg_top

// ===== verif/spicfg_peer.sv
// Serial peripheral model: shifts a reply out, captures the command byte
`timescale 1ns/100ps
module spicfg_peer #(
	parameter logic [7:0] REPLY = 8'h3C
) (
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	output logic            miso,
	output logic [7:0]      got
);
	logic [7:0] sh;
	initial miso = 1'b0;
	// Phase one, idle low: capture on rise, change on fall
	always @(negedge cs_n) begin
		sh = REPLY;
		miso = REPLY[7];
	end
	always @(posedge sck) if (!cs_n) got <= {got[6:0], mosi};
	always @(negedge sck) if (!cs_n) begin
		sh = sh << 1;
		miso = sh[7];
	end
	// Released line must not look like held data
	always @(posedge cs_n) miso = ~miso;
endmodule : spicfg_peer

// ===== verif/tb.sv
// Self-checking bench for the serial controller
`timescale 1ns/100ps
module tb;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0, got;
	logic [31:0] wdata = 0, rdata, v;
	logic [3:0] wstrb = 4'hF, sel;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid, sck, mosi, miso, irq, ssi = 1, lv = 0;
	int error_cnt = 0, n_compared = 0, cyc = 0, nck = 0;
	realtime t_last;
	always #50 aclk = ~aclk;
	spicfg_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.serial_clock(sck), .mosi_out(mosi), .miso_in(miso), .peripheral_select_out(sel),
		.slave_select_in(ssi), .rx_end_in(lv), .tx_end_in(lv), .rx_buffer_full_in(lv),
		.tx_buffer_empty_in(lv), .irq(irq));
	spicfg_peer u_peer (.sck(sck), .cs_n(sel[0]), .mosi(mosi), .miso(miso), .got(got));
	always @(posedge sck) nck++;
	always @(negedge sck) t_last = $realtime;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Readies are sampled mid-cycle; they only change at rising edges
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			@(posedge aclk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
		end while (awvalid & !ta | wvalid & !tw);
		do @(negedge aclk); while (!bvalid);
		r = bresp;
		@(posedge aclk);
		bready <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 0;
		do @(negedge aclk); while (!rvalid);
		v = rdata; r = rresp;
		@(posedge aclk);
		rready <= 0;
	endtask : rd
	task automatic t_regs;
		rd(spicfg_pkg::OFS_IEN_STATE); chk("mask_rst", 32'h0, v);
		rd(spicfg_pkg::OFS_CS0); chk("cs0_rst", 32'h0, v);
		wr(spicfg_pkg::OFS_IEN_SET, 32'hFFFFFFFF);
		rd(spicfg_pkg::OFS_IEN_STATE); chk("mask_all", 32'h3FF, v);
		wr(spicfg_pkg::OFS_IEN_CLR, 32'h155);
		wr(spicfg_pkg::OFS_IEN_SET, 32'h0);
		rd(spicfg_pkg::OFS_IEN_STATE); chk("mask_part", 32'h2AA, v);
		wr(spicfg_pkg::OFS_IEN_CLR, 32'hFFFFFFFF);
		rd(spicfg_pkg::OFS_IEN_STATE); chk("mask_none", 32'h0, v);
		wr(8'h3C, 32'hFFFFFFFF);
		rd(8'h3C); chk("cs3_rw", 32'hFFFFFFFB, v);
		rd(8'hF0); chk("unmapped", {30'h0, spicfg_pkg::RESP_SLVERR}, {30'h0, r});
	endtask : t_regs
	task automatic t_nss;
		wr(spicfg_pkg::OFS_IEN_SET, 32'h100);
		lv <= 1; ssi <= 0;
		repeat (6) @(posedge aclk);
		chk("irq_quiet", 32'h0, {31'h0, irq});
		ssi <= 1;
		repeat (6) @(posedge aclk);
		chk("irq_rise", 32'h1, {31'h0, irq});
		rd(spicfg_pkg::OFS_STATUS); chk("st_rise", 32'h3F0, v & 32'h3F0);
		repeat (3) @(posedge aclk);
		chk("irq_clr", 32'h0, {31'h0, irq});
		rd(spicfg_pkg::OFS_STATUS); chk("st_clr", 32'h0, v & 32'h100);
		lv <= 0;
		wr(spicfg_pkg::OFS_IEN_CLR, 32'h100);
	endtask : t_nss
	task automatic t_xfer;
		int k;
		wr(spicfg_pkg::OFS_CS0, 32'h01001002);
		wr(spicfg_pkg::OFS_MODE, 32'h1);
		nck = 0;
		wr(spicfg_pkg::OFS_TDATA, 32'hA5);
		rd(spicfg_pkg::OFS_STATUS); chk("tx_busy", 32'h0, v & 32'h200);
		chk("sel_on", 32'hE, {28'h0, sel});
		k = 0;
		while (sel !== 4'hF && k < 2000) begin
			@(posedge aclk);
			k++;
		end
		chk("bits", 32'd8, nck);
		chk("itd_wait", 32'h1, {31'h0, ($realtime - t_last) >= 3200.0});
		chk("peer_got", 32'hA5, {24'h0, got});
		// The deselect gap still counts as busy
		repeat (8) @(posedge aclk);
		rd(spicfg_pkg::OFS_STATUS); chk("tx_done", 32'h200, v & 32'h200);
		rd(spicfg_pkg::OFS_RDATA); chk("rx_word", 32'h3C, v);
		chk("sck_idle", 32'h0, {31'h0, sck});
	endtask : t_xfer
	task automatic t_hold;
		wr(spicfg_pkg::OFS_CS0, 32'h0000100A);
		wr(spicfg_pkg::OFS_MODE, 32'h3);
		wr(spicfg_pkg::OFS_TDATA, 32'h5A);
		repeat (300) @(posedge aclk);
		chk("sel_held", 32'hE, {28'h0, sel});
		chk("peer_first", 32'h5A, {24'h0, got});
		wr(spicfg_pkg::OFS_TDATA, 32'h010000C3);
		repeat (300) @(posedge aclk);
		chk("sel_last", 32'hF, {28'h0, sel});
		chk("peer_last", 32'hC3, {24'h0, got});
	endtask : t_hold
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			stop_test;
		end
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		t_regs;
		t_nss;
		t_xfer;
		t_hold;
		stop_test;
	end
endmodule : tb
